// [dshp_pkg.sv]
// Constants shared by the dual-style host port controller.
package dshp_pkg;

    // Device register map
    localparam logic [7:0] DSHP_CHIP_ACCESS_CONTROL_ADDR = 8'h02;
    localparam logic [7:0] DSHP_FIRST_FORBIDDEN_ADDR = 8'hE8;
    localparam logic [7:0] DSHP_LAST_FORBIDDEN_ADDR = 8'hFF;
    localparam int DSHP_CHIP_ID_LSB = 0;
    localparam int DSHP_CHIP_ID_WIDTH = 4;
    localparam logic [7:0] DSHP_CHIP_ACCESS_CONTROL_RESET = 8'h00;

    // Widths
    localparam int DSHP_ADDR_WIDTH = 8;
    localparam int DSHP_DATA_WIDTH = 16;
    localparam int DSHP_LANES = 2;

    // Port clock: system clock divided down, well below 100 MHz
    localparam int DSHP_SYS_CLK_PERIOD_NS = 25;
    localparam int DSHP_PORT_CLK_DIV = 4;
    localparam int DSHP_DIV_WIDTH = 2;
    localparam logic [1:0] DSHP_DIV_LAST = 2'h3;
    localparam logic [1:0] DSHP_DIV_HIGH = 2'h2;

    // Longest wait for a handshake edge before giving up
    localparam int DSHP_TIMEOUT_NS = 50000;
    localparam int DSHP_TIMEOUT_CYC = DSHP_TIMEOUT_NS / DSHP_SYS_CLK_PERIOD_NS;
    localparam int DSHP_TIMER_WIDTH = 12;

    // Bus style and serial select strap levels
    localparam logic DSHP_STYLE_SEPARATE = 1'b0;
    localparam logic DSHP_STYLE_SINGLE = 1'b1;
    localparam logic DSHP_SERIAL_SELECT_PARALLEL = 1'b0;

    typedef enum logic [2:0] {
        DSHP_IDLE      = 3'h0,
        DSHP_SETUP     = 3'h1,
        DSHP_SELECT    = 3'h3,
        DSHP_WAIT_BUSY = 3'h2,
        DSHP_WAIT_DONE = 3'h6,
        DSHP_RELEASE   = 3'h7,
        DSHP_WAIT_IDLE = 3'h5
    } dshp_state_t;

endpackage

// [dshp_sync.sv]
// Two-flop synchroniser for signals arriving from the device pins.
module dshp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// [dshp_host.sv]
// Host controller driving the device's parallel programming port in either bus style.
module dshp_host
    import dshp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    // User side
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [DSHP_ADDR_WIDTH-1:0] cmd_addr,
    input wire logic [DSHP_DATA_WIDTH-1:0] cmd_wdata,
    input wire logic cmd_wide,
    input wire logic style_select,
    input wire logic device_reset_request,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [DSHP_DATA_WIDTH-1:0] rsp_rdata,
    // Device side
    output logic host_port_clock,
    output logic device_reset_n,
    output logic serial_select_strap,
    output logic bus_style_strap,
    output logic [DSHP_ADDR_WIDTH-1:0] port_addr,
    output logic [DSHP_DATA_WIDTH-1:0] port_data_out,
    output logic [DSHP_LANES-1:0] port_data_oe,
    input wire logic [DSHP_DATA_WIDTH-1:0] port_data_in,
    output logic chip_select_n,
    output logic write_or_rw_n,
    output logic read_or_data_strobe_n,
    input wire logic transfer_ack_n
);

    logic [DSHP_DIV_WIDTH-1:0] div_q;
    logic tick;
    dshp_state_t state_q;
    logic style_q;
    logic write_q;
    logic wide_q;
    logic [DSHP_TIMER_WIDTH-1:0] timer_q;
    logic timed_out;
    logic hs_line;
    logic [DSHP_DATA_WIDTH-1:0] data_sync;
    logic forbidden;
    logic done_seen;

    // The handshake is open drain with a pull-up, so idle reads as high
    dshp_sync #(
        .WIDTH(1),
        .RESET_VALUE(1'b1)
    ) u_sync_hs (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(transfer_ack_n),
        .sync_out(hs_line)
    );

    dshp_sync #(
        .WIDTH(DSHP_DATA_WIDTH),
        .RESET_VALUE('0)
    ) u_sync_data (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(port_data_in),
        .sync_out(data_sync)
    );

    // Port clock from a free-running divider; select, strobes and data enables change only at its falling edge,
    // giving half a port period of setup before the device samples on the rising edge.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    assign tick = (div_q == DSHP_DIV_LAST);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_port_clock <= 1'b0;
        end else begin
            host_port_clock <= (div_q + 2'h1) >= DSHP_DIV_HIGH;
        end
    end

    // Straps and device reset; style is only retaken while the port is idle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_select_strap <= DSHP_SERIAL_SELECT_PARALLEL;
            bus_style_strap <= DSHP_STYLE_SEPARATE;
            style_q <= DSHP_STYLE_SEPARATE;
            device_reset_n <= 1'b0;
        end else begin
            serial_select_strap <= DSHP_SERIAL_SELECT_PARALLEL;
            device_reset_n <= ~device_reset_request;
            if (state_q == DSHP_IDLE) begin
                style_q <= style_select;
                bus_style_strap <= style_select;
            end
        end
    end

    assign forbidden = (cmd_addr >= DSHP_FIRST_FORBIDDEN_ADDR) && (cmd_addr <= DSHP_LAST_FORBIDDEN_ADDR);

    // Completion level differs per style: ready returns high, acknowledge goes low
    assign done_seen = (style_q == DSHP_STYLE_SEPARATE) ? hs_line : ~hs_line;

    assign timed_out = (timer_q == DSHP_TIMER_WIDTH'(DSHP_TIMEOUT_CYC - 1));

    // Watchdog: a device whose chip ID does not match never handshakes, so the
    // host would otherwise wait forever. Restarts whenever the waiting states are left.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_q <= '0;
        end else if (state_q == DSHP_WAIT_BUSY || state_q == DSHP_WAIT_DONE || state_q == DSHP_WAIT_IDLE) begin
            if (!timed_out) begin
                timer_q <= timer_q + 12'h001;
            end
        end else begin
            timer_q <= '0;
        end
    end

    // Access sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= DSHP_IDLE;
            write_q <= 1'b0;
            wide_q <= 1'b0;
        end else begin
            unique case (state_q)
                DSHP_IDLE: begin
                    if (cmd_valid && cmd_ready && !forbidden && device_reset_n) begin
                        write_q <= cmd_write;
                        wide_q <= cmd_wide;
                        state_q <= DSHP_SETUP;
                    end
                end
                DSHP_SETUP: begin
                    if (tick) begin
                        state_q <= DSHP_SELECT;
                    end
                end
                DSHP_SELECT: begin
                    if (tick) begin
                        state_q <= (style_q == DSHP_STYLE_SEPARATE) ? DSHP_WAIT_BUSY : DSHP_WAIT_DONE;
                    end
                end
                DSHP_WAIT_BUSY: begin
                    if (timed_out) begin
                        state_q <= DSHP_RELEASE;
                    end else if (!hs_line) begin
                        state_q <= DSHP_WAIT_DONE;
                    end
                end
                DSHP_WAIT_DONE: begin
                    if (timed_out || done_seen) begin
                        state_q <= DSHP_RELEASE;
                    end
                end
                DSHP_RELEASE: begin
                    if (tick) begin
                        state_q <= DSHP_WAIT_IDLE;
                    end
                end
                DSHP_WAIT_IDLE: begin
                    // Acknowledge must be back high before the next access
                    if (hs_line || timed_out) begin
                        state_q <= DSHP_IDLE;
                    end
                end
                default: begin
                    state_q <= DSHP_IDLE;
                end
            endcase
        end
    end

    // Address, data and strobe pins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_addr <= '0;
            port_data_out <= '0;
            port_data_oe <= '0;
            chip_select_n <= 1'b1;
            write_or_rw_n <= 1'b1;
            read_or_data_strobe_n <= 1'b1;
        end else begin
            if (state_q == DSHP_IDLE && cmd_valid && cmd_ready && !forbidden && device_reset_n) begin
                port_addr <= cmd_addr;
                port_data_out <= cmd_wide ? cmd_wdata : {8'h00, cmd_wdata[7:0]};
            end
            if (state_q == DSHP_SETUP && tick) begin
                if (write_q) begin
                    port_data_oe <= {wide_q, 1'b1};
                end else begin
                    port_data_oe <= '0;
                end
                if (style_q == DSHP_STYLE_SEPARATE) begin
                    write_or_rw_n <= ~write_q;
                    read_or_data_strobe_n <= write_q;
                end else begin
                    write_or_rw_n <= ~write_q;
                    read_or_data_strobe_n <= 1'b0;
                end
            end
            if (state_q == DSHP_SELECT && tick) begin
                chip_select_n <= 1'b0;
            end
            if (state_q == DSHP_RELEASE && tick) begin
                // Select and strobes rise together, which frees the acknowledge
                chip_select_n <= 1'b1;
                write_or_rw_n <= 1'b1;
                read_or_data_strobe_n <= 1'b1;
                port_data_oe <= '0;
            end
        end
    end

    // User handshake and read data (register values or output words alike)
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            cmd_ready <= (state_q == DSHP_IDLE) && !(cmd_valid && cmd_ready);
            if (state_q == DSHP_IDLE && cmd_valid && cmd_ready && (forbidden || !device_reset_n)) begin
                // Refused without touching the bus: forbidden addresses would hang it, and a device held in reset cannot answer
                rsp_valid <= 1'b1;
                rsp_error <= 1'b1;
                rsp_rdata <= '0;
            end
            if ((state_q == DSHP_WAIT_BUSY && timed_out) || (state_q == DSHP_WAIT_DONE && (timed_out || done_seen))) begin
                rsp_valid <= 1'b1;
                rsp_error <= timed_out;
                if (!write_q && !timed_out) begin
                    rsp_rdata <= wide_q ? data_sync : {8'h00, data_sync[7:0]};
                end else begin
                    rsp_rdata <= '0;
                end
            end
        end
    end

endmodule

// [dshp_host_properties.sv]
// Assertions on the host port controller's pins and user side.
module dshp_host_checker
    import dshp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [DSHP_ADDR_WIDTH-1:0] cmd_addr,
    input wire logic rsp_valid,
    input wire logic rsp_error,
    input wire logic host_port_clock,
    input wire logic serial_select_strap,
    input wire logic bus_style_strap,
    input wire logic [DSHP_ADDR_WIDTH-1:0] port_addr,
    input wire logic [DSHP_LANES-1:0] port_data_oe,
    input wire logic chip_select_n,
    input wire logic write_or_rw_n,
    input wire logic read_or_data_strobe_n,
    input wire logic transfer_ack_n
);
    default clocking dcb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    logic bad_take;
    logic sep_strobe;
    logic read_phase;
    assign bad_take = cmd_valid && cmd_ready && cmd_addr >= DSHP_FIRST_FORBIDDEN_ADDR;
    assign sep_strobe = !write_or_rw_n || !read_or_data_strobe_n;
    assign read_phase = bus_style_strap ? write_or_rw_n : !read_or_data_strobe_n;
    a_serial_strap_low: assert property (!serial_select_strap)
        else $error("serial strap high");
    a_bad_addr_refused: assert property (bad_take |-> ##[1:2] rsp_valid && rsp_error)
        else $error("forbidden address not refused");
    a_bad_addr_unselected: assert property (bad_take |=> chip_select_n [*3])
        else $error("forbidden address selected");
    a_sep_strobe_first: assert property ($fell(chip_select_n) && !bus_style_strap |-> $past(sep_strobe))
        else $error("select before strobe");
    a_single_strobe_first: assert property ($fell(chip_select_n) && bus_style_strap |-> !$past(read_or_data_strobe_n))
        else $error("select before data strobe");
    a_read_bus_free: assert property (!chip_select_n && read_phase |-> port_data_oe == 2'h0)
        else $error("data driven during read");
    a_sep_ready_wait: assert property ($rose(chip_select_n) && !bus_style_strap && !rsp_error |-> $past(transfer_ack_n, 2))
        else $error("select released before ready");
    a_single_ack_wait: assert property ($rose(chip_select_n) && bus_style_strap && !rsp_error |-> !$past(transfer_ack_n, 2))
        else $error("select released before acknowledge");
    a_addr_held: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(port_addr) && $stable(write_or_rw_n))
        else $error("address moved during access");
    a_port_clock_div: assert property ($rose(host_port_clock) |-> host_port_clock [*2] ##1 !host_port_clock [*2] ##1 host_port_clock)
        else $error("port clock not divided by four");
    a_pins_on_fall: assert property ($changed(chip_select_n) |-> $fell(host_port_clock))
        else $error("select moved off port clock fall");
endmodule

bind dshp_host dshp_host_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .host_port_clock(host_port_clock), .serial_select_strap(serial_select_strap), .bus_style_strap(bus_style_strap),
    .port_addr(port_addr), .port_data_oe(port_data_oe), .chip_select_n(chip_select_n),
    .write_or_rw_n(write_or_rw_n), .read_or_data_strobe_n(read_or_data_strobe_n), .transfer_ack_n(transfer_ack_n));

// [dshp_dev_model.sv]
// Behavioural model of the device's parallel programming port.
module dshp_dev_model
    import dshp_pkg::*;
#(
    parameter logic [3:0] SLOT_ID = 4'h0,
    parameter int WIDE_BIT = 7
) (
    input wire logic host_port_clock,
    input wire logic device_reset_n,
    input wire logic serial_select_strap,
    input wire logic bus_style_strap,
    input wire logic [7:0] port_addr,
    input wire logic [15:0] data_pins,
    input wire logic chip_select_n,
    input wire logic write_or_rw_n,
    input wire logic read_or_data_strobe_n,
    input wire logic [2:0] latency,
    output logic ack_pull,
    output logic [15:0] dev_data,
    output logic [1:0] dev_oe
);
    logic [15:0] mem [256];
    logic [1:0] st;
    logic [2:0] cnt;
    logic wide;
    logic start;
    assign wide = mem[DSHP_CHIP_ACCESS_CONTROL_ADDR][WIDE_BIT];
    // Mismatched ID or forbidden address: stay idle, never touch the lines
    assign start = !chip_select_n && !serial_select_strap && port_addr < DSHP_FIRST_FORBIDDEN_ADDR
        && mem[DSHP_CHIP_ACCESS_CONTROL_ADDR][DSHP_CHIP_ID_LSB +: DSHP_CHIP_ID_WIDTH] == SLOT_ID
        && (!read_or_data_strobe_n || (!bus_style_strap && !write_or_rw_n));
    always @(posedge host_port_clock or negedge device_reset_n) begin
        if (!device_reset_n) begin
            st <= 2'h0;
            ack_pull <= 1'b0;
            dev_oe <= 2'h0;
            mem[DSHP_CHIP_ACCESS_CONTROL_ADDR] <= {8'h00, DSHP_CHIP_ACCESS_CONTROL_RESET};
        end else if (st == 2'h0 && start) begin
            st <= 2'h1;
            cnt <= latency;
            ack_pull <= !bus_style_strap;
        end else if (st == 2'h1 && cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end else if (st == 2'h1) begin
            st <= 2'h2;
            ack_pull <= bus_style_strap;
            if (!write_or_rw_n)
                mem[port_addr] <= wide ? data_pins : {8'h00, data_pins[7:0]};
            else
                dev_oe <= {wide, 1'b1};
            dev_data <= mem[port_addr];
        end else if (st == 2'h2 && (chip_select_n || (bus_style_strap && read_or_data_strobe_n))) begin
            st <= 2'h0;
            ack_pull <= 1'b0;
            dev_oe <= 2'h0;
        end
    end
endmodule

// [dshp_host_tb_top.sv]
// Self-checking bench for the dual-style host port controller.
module dshp_host_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dshp_pkg::*;
    logic sys_clk = 0, sys_rst = 1, cmd_valid = 0, cmd_write = 0, cmd_wide = 0, style_select = 0;
    logic device_reset_request = 0, wide_q = 0;
    logic [7:0] cmd_addr = 0, a;
    logic [15:0] cmd_wdata = 0, d, noise = 16'h5A3C;
    logic [2:0] latency = 0;
    logic cmd_ready, rsp_valid, rsp_error, host_port_clock, device_reset_n, serial_select_strap, bus_style_strap;
    logic chip_select_n, write_or_rw_n, read_or_data_strobe_n, ack_pull;
    logic [7:0] port_addr;
    logic [15:0] port_data_out, rsp_rdata, dev_data, pins;
    logic [1:0] port_data_oe, dev_oe;
    logic [16:0] e;
    logic [16:0] expq[$];
    int fails = 0, n_compared = 0;
    // Undriven lanes toggle so a stale value can never be read back
    assign pins[7:0] = port_data_oe[0] ? port_data_out[7:0] : dev_oe[0] ? dev_data[7:0] : noise[7:0];
    assign pins[15:8] = port_data_oe[1] ? port_data_out[15:8] : dev_oe[1] ? dev_data[15:8] : noise[15:8];
    wire transfer_ack_n = !ack_pull;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) noise <= ~noise;
    dshp_host uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wide(cmd_wide), .style_select(style_select),
        .device_reset_request(device_reset_request), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .host_port_clock(host_port_clock),
        .device_reset_n(device_reset_n), .serial_select_strap(serial_select_strap),
        .bus_style_strap(bus_style_strap), .port_addr(port_addr), .port_data_out(port_data_out),
        .port_data_oe(port_data_oe), .port_data_in(pins), .chip_select_n(chip_select_n),
        .write_or_rw_n(write_or_rw_n), .read_or_data_strobe_n(read_or_data_strobe_n), .transfer_ack_n(transfer_ack_n));
    dshp_dev_model dev (.host_port_clock(host_port_clock), .device_reset_n(device_reset_n),
        .serial_select_strap(serial_select_strap), .bus_style_strap(bus_style_strap), .port_addr(port_addr),
        .data_pins(pins), .chip_select_n(chip_select_n), .write_or_rw_n(write_or_rw_n),
        .read_or_data_strobe_n(read_or_data_strobe_n), .latency(latency), .ack_pull(ack_pull),
        .dev_data(dev_data), .dev_oe(dev_oe));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One request, expectation noted right after it is presented, before the host can take it
    task automatic acc(logic w, logic [7:0] ad, logic [15:0] wd, logic err, logic [15:0] rd);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_valid = 1;
        cmd_write = w;
        cmd_addr = ad;
        cmd_wdata = wd;
        cmd_wide = wide_q;
        latency = 3'($urandom_range(0, 6));
        expq.push_back({err, rd});
        // Ready seen high off the edge still stands at the next rising edge, which takes the request
        while (cmd_ready !== 1'b1 && n++ < 9000) @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 0;
        while (cmd_ready !== 1'b1 && n++ < 9000) @(negedge sys_clk);
        if (n > 9000)
            fails++;
    endtask
    // Outputs are looked at mid-cycle, where the registered response has settled
    always @(negedge sys_clk) begin
        if (rsp_valid === 1'b1) begin
            e = expq.size() > 0 ? expq.pop_front() : 17'h1FFFF;
            chk("rsp_error", {15'h0, e[16]}, {15'h0, rsp_error});
            chk("rsp_rdata", e[15:0], rsp_rdata);
        end
    end
    initial begin
        #(20000 * 25);
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(80758));
        repeat (20) @(negedge sys_clk);
        sys_rst = 0;
        for (int s = 0; s < 2; s++) begin
            style_select = s[0];
            d = 16'($urandom);
            a = 8'($urandom_range(8'h10, 8'hE7));
            wide_q = 0;
            acc(1, a, d, 0, 16'h0);
            acc(0, a, 16'h0, 0, {8'h00, d[7:0]});
            acc(1, DSHP_CHIP_ACCESS_CONTROL_ADDR, 16'h0080, 0, 16'h0);
            wide_q = 1;
            acc(1, a, d, 0, 16'h0);
            acc(0, a, 16'h0, 0, d);
            acc(1, DSHP_CHIP_ACCESS_CONTROL_ADDR, 16'h0000, 0, 16'h0);
            wide_q = 0;
            acc(1, DSHP_FIRST_FORBIDDEN_ADDR, d, 1, 16'h0);
            acc(0, DSHP_LAST_FORBIDDEN_ADDR, 16'h0, 1, 16'h0);
            $display("style %0d test done", s);
        end
        style_select = 0;
        acc(1, DSHP_CHIP_ACCESS_CONTROL_ADDR, 16'h0005, 0, 16'h0);
        acc(0, a, 16'h0, 1, 16'h0);
        device_reset_request = 1;
        acc(0, a, 16'h0, 1, 16'h0);
        device_reset_request = 0;
        repeat (8) @(negedge sys_clk);
        acc(0, DSHP_CHIP_ACCESS_CONTROL_ADDR, 16'h0, 0, {8'h00, DSHP_CHIP_ACCESS_CONTROL_RESET});
        $display("chip id and reset test done");
        chk("responses left", 16'h0, 16'(expq.size()));
        test_done();
    end
endmodule
